// >>> dv/ltpm_regs_tb.sv
`default_nettype none

module ltpm_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in;
    logic rst_in;
    logic [15:0] addr_in;
    logic [15:0] wr_data_in;
    logic wr_in;
    logic rd_in;
    logic [15:0] rd_data_out;
    logic [255:0] freq_coarse_in;
    logic [255:0] freq_fine_in;
    logic [47:0] hires_freq_in;
    logic [15:0] hires_en_in;
    logic pm_sample_valid_in;
    logic [255:0] tx_power_in;
    logic [255:0] rx_power_in;
    logic [47:0] hires_min_freq_out;
    logic [15:0] use_hires_out;
    logic [15:0] retune_out;
    logic pm_interval_end_out;
    int err_total;
    int n_tests;
    logic [31:0] seed;
    logic [31:0] r;
    logic [15:0] a;
    logic [15:0] m;
    logic [15:0] old;
    logic [15:0] wv [3];
    logic signed [15:0] tv;
    logic signed [15:0] rv;
    logic signed [15:0] tmn [16];
    logic signed [15:0] tmx [16];
    int sum_t [16];
    int sum_r [16];
    logic seen;
    logic [15:0] rsvb [3] = '{16'hb440, 16'hb470, 16'hb480};
    logic [15:0] rsvx [12] = '{16'hb493, 16'hb494, 16'hb495, 16'hb499, 16'hb49a, 16'hb49b,
                               16'hb49c, 16'hb49d, 16'hb49e, 16'hb49f, 16'hb500, 16'h0000};

    ltpm_regs dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rd_data_out(rd_data_out),
        .freq_coarse_in(freq_coarse_in),
        .freq_fine_in(freq_fine_in),
        .hires_freq_in(hires_freq_in),
        .hires_en_in(hires_en_in),
        .pm_sample_valid_in(pm_sample_valid_in),
        .tx_power_in(tx_power_in),
        .rx_power_in(rx_power_in),
        .hires_min_freq_out(hires_min_freq_out),
        .use_hires_out(use_hires_out),
        .retune_out(retune_out),
        .pm_interval_end_out(pm_interval_end_out)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // floor division by the interval length, as the arithmetic shift gives
    function automatic logic [15:0] avg_of(input int sum);
        int q;
        q = sum >>> 8;
        return q[15:0];
    endfunction : avg_of

    task automatic summarize;
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // every bus task ends 1 ns after an edge, so strobes never get two drives in one step
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick

    task automatic bus_wr(input logic [15:0] ad, input logic [15:0] d);
        wr_in <= 1'b1;
        addr_in <= ad;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic rd_chk(input string what, input logic [15:0] ad, input logic [15:0] exp);
        rd_in <= 1'b1;
        addr_in <= ad;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check(what, 48'(rd_data_out), 48'(exp));
    endtask : rd_chk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'd64607;
        err_total = 0;
        n_tests = 0;
        rst_in = 1'b1;
        addr_in = 16'h0000;
        wr_data_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        freq_coarse_in = '0;
        freq_fine_in = '0;
        hires_freq_in = '0;
        hires_en_in = 16'h0000;
        pm_sample_valid_in = 1'b0;
        tx_power_in = '0;
        rx_power_in = '0;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        tick;
        for (int l = 0; l < 16; l++)
            for (int k = 0; k < 6; k++)
                rd_chk("stat reset", 16'hb4a0 + 16'(k * 16 + l), 16'h0000);
        check("min out reset", hires_min_freq_out, 48'h0);
        // live frequency inputs, with the fine limit and all-ones coarse as corners
        for (int l = 0; l < 16; l++)
        begin
            r = rnd();
            freq_coarse_in[16*l +: 16] <= (l == 15) ? 16'hffff : r[15:0];
            freq_fine_in[16*l +: 16] <= (l == 0) ? 16'd19999 : 16'(r[31:16] % 20000);
        end
        r = rnd();
        hires_freq_in <= {r[15:0], rnd()};
        tick;
        for (int l = 0; l < 16; l++)
        begin
            rd_chk("coarse", 16'hb450 + 16'(l), freq_coarse_in[16*l +: 16]);
            rd_chk("fine", 16'hb460 + 16'(l), freq_fine_in[16*l +: 16]);
        end
        for (int k = 0; k < 3; k++)
        begin
            bus_wr(16'hb496 + 16'(k), 16'h5a5a);
            rd_chk("hires read", 16'hb496 + 16'(k), hires_freq_in[16*k +: 16]);
        end
        // write then read the same word with no gap
        for (int k = 0; k < 3; k++)
        begin
            r = rnd();
            wv[k] = r[15:0];
            bus_wr(16'hb490 + 16'(k), wv[k]);
            rd_chk("min word", 16'hb490 + 16'(k), wv[k]);
        end
        check("min out", hires_min_freq_out, {wv[2], wv[1], wv[0]});
        tick;
        check("read idle", 48'(rd_data_out), 48'h0);
        for (int i = 0; i < 60; i++)
        begin
            a = (i < 48) ? rsvb[i / 16] + 16'(i % 16) : rsvx[i - 48];
            r = rnd();
            bus_wr(a, r[15:0] | 16'h0001);
            rd_chk("reserved", a, 16'h0000);
        end
        bus_wr(16'hb450, 16'h1234);
        rd_chk("coarse ro", 16'hb450, freq_coarse_in[15:0]);
        bus_wr(16'hb4a0, 16'h1234);
        rd_chk("tx now ro", 16'hb4a0, 16'h0000);
        check("min out kept", hires_min_freq_out, {wv[2], wv[1], wv[0]});
        // tuning mode follows the enable bit one cycle later
        old = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            m = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : (i == 7) ? 16'h8421 : r[15:0];
            hires_en_in <= m;
            tick;
            check("use hires", 48'(use_hires_out), 48'(m));
            check("retune", 48'(retune_out), 48'(m ^ old));
            old = m;
        end
        tick;
        check("retune idle", 48'(retune_out), 48'h0);
        bus_wr(16'hb491, wv[1]);
        seen = 1'b0;
        for (int w = 0; w < 4 && !seen; w++)
        begin
            if (retune_out === old)
                seen = 1'b1;
            else
                tick;
        end
        check("retune on write", 48'(seen), 48'h1);
        if (!seen)
            summarize();
        // ----------------------------------------------------------------
        // two monitoring intervals; the second is narrow so stale extremes show
        // ----------------------------------------------------------------
        for (int iv = 0; iv < 2; iv++)
        begin
            for (int l = 0; l < 16; l++)
            begin
                sum_t[l] = 0;
                sum_r[l] = 0;
                tmn[l] = 16'sh7fff;
                tmx[l] = 16'sh8000;
            end
            pm_sample_valid_in <= 1'b1;
            for (int s = 0; s < 256; s++)
            begin
                for (int l = 0; l < 16; l++)
                begin
                    r = rnd();
                    tv = (iv == 0) ? r[15:0] : {8'h00, r[7:0]};
                    rv = (iv == 0) ? r[31:16] : {8'hff, r[23:16]};
                    if (iv == 0 && l == 0 && s < 2)
                        tv = (s == 0) ? 16'sh8000 : 16'sh7fff;
                    sum_t[l] += int'(tv);
                    sum_r[l] += int'(rv);
                    if (tv < tmn[l])
                        tmn[l] = tv;
                    if (tv > tmx[l])
                        tmx[l] = tv;
                    tx_power_in[16*l +: 16] <= tv;
                    rx_power_in[16*l +: 16] <= rv;
                end
                tick;
                if (s < 255)
                    check("no interval end", 48'(pm_interval_end_out), 48'h0);
            end
            pm_sample_valid_in <= 1'b0;
            seen = 1'b0;
            for (int w = 0; w < 3 && !seen; w++)
            begin
                if (pm_interval_end_out === 1'b1)
                    seen = 1'b1;
                else
                    tick;
            end
            check("interval end", 48'(seen), 48'h1);
            if (!seen)
                summarize();
            tick;
            for (int l = 0; l < 16; l++)
            begin
                a = 16'(l);
                rd_chk("tx now", 16'hb4a0 + a, tx_power_in[16*l +: 16]);
                rd_chk("tx avg", 16'hb4b0 + a, avg_of(sum_t[l]));
                rd_chk("tx min", 16'hb4c0 + a, tmn[l]);
                rd_chk("tx max", 16'hb4d0 + a, tmx[l]);
                rd_chk("rx now", 16'hb4e0 + a, rx_power_in[16*l +: 16]);
                rd_chk("rx avg", 16'hb4f0 + a, avg_of(sum_r[l]));
            end
        end
        // a reset in mid-run must clear what the intervals left behind
        rst_in <= 1'b1;
        tick;
        tick;
        rst_in <= 1'b0;
        tick;
        check("min out rerun", hires_min_freq_out, 48'h0);
        for (int l = 0; l < 16; l++)
        begin
            rd_chk("tx max rerun", 16'hb4d0 + 16'(l), 16'h0000);
            rd_chk("rx avg rerun", 16'hb4f0 + 16'(l), 16'h0000);
        end
        summarize();
    end

endmodule : ltpm_regs_tb

`default_nettype wire

// >>> rtl/ltpm_defs.svh
// Overview of operation
// RULE1 - coarse transmit frequency reads back as unsigned 16 bits, 1 thz per count
// RULE2 - fine transmit frequency reads back unsigned, 0.05 ghz per count, at most 19999 (the code passes freq_fine_in through with no limit)
// RULE3 - all power monitor values are signed 16 bits, 0.01 dbm per count
// RULE4 - per lane transmit power now, average, minimum, maximum; read only, reset to zero
// RULE5 - per lane receive power now and average; read only, reset to zero
// RULE6 - three writable minimum frequency words, then three reserved locations
// RULE7 - three read only tuned frequency words, then seven reserved locations
// RULE8 - each lane block holds sixteen registers, lane index from zero
// RULE9 - high resolution words are used only while the lane enable bit is set
// RULE10 - reserved locations read as zero and ignore writes
`ifndef LTPM_DEFS_SVH
`define LTPM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (word addresses)
// ----------------------------------------------------------------
`define LTPM_OFF_RSVD_A 16'hb440
`define LTPM_OFF_FREQ_COARSE 16'hb450
`define LTPM_OFF_FREQ_FINE 16'hb460
`define LTPM_OFF_RSVD_B 16'hb470
`define LTPM_OFF_RSVD_C 16'hb480
`define LTPM_OFF_MIN_FREQ1 16'hb490
`define LTPM_OFF_MIN_FREQ2 16'hb491
`define LTPM_OFF_MIN_FREQ3 16'hb492
`define LTPM_OFF_FREQ_RD1 16'hb496
`define LTPM_OFF_FREQ_RD2 16'hb497
`define LTPM_OFF_FREQ_RD3 16'hb498
`define LTPM_OFF_TX_NOW 16'hb4a0
`define LTPM_OFF_TX_AVG 16'hb4b0
`define LTPM_OFF_TX_MIN 16'hb4c0
`define LTPM_OFF_TX_MAX 16'hb4d0
`define LTPM_OFF_RX_NOW 16'hb4e0
`define LTPM_OFF_RX_AVG 16'hb4f0

// ----------------------------------------------------------------
// sizes, reset values, monitoring interval
// ----------------------------------------------------------------
`define LTPM_NUM_LANES 16
`define LTPM_WORD_RESET 16'h0000
`define LTPM_FINE_MAX 16'h4e1f
`define LTPM_PM_SHIFT 8
`define LTPM_PM_LAST 8'hff

`endif

// >>> rtl/ltpm_pkg.sv
`default_nettype none

package ltpm_pkg;

    typedef logic [15:0] ltpm_word_t;

    // which register group answers a read
    typedef enum logic [3:0] {
        LTPM_SRC_NONE,
        LTPM_SRC_COARSE,
        LTPM_SRC_FINE,
        LTPM_SRC_MIN_FREQ,
        LTPM_SRC_FREQ_RD,
        LTPM_SRC_TX_NOW,
        LTPM_SRC_TX_AVG,
        LTPM_SRC_TX_MIN,
        LTPM_SRC_TX_MAX,
        LTPM_SRC_RX_NOW,
        LTPM_SRC_RX_AVG
    } ltpm_src_t;

endpackage : ltpm_pkg

`default_nettype wire

// >>> rtl/ltpm_pm_stats.sv
`include "ltpm_defs.svh"
`default_nettype none

module ltpm_pm_stats (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sample_valid_in,
    input wire logic interval_end_in,
    input wire logic [15:0] sample_in,
    output logic [15:0] now_out,
    output logic [15:0] avg_out,
    output logic [15:0] min_out,
    output logic [15:0] max_out
);

    // ----------------------------------------------------------------
    // running statistics over one monitoring interval
    // ----------------------------------------------------------------
    // the interval is a power of two samples so the average is a shift
    logic signed [23:0] sum_reg;
    logic signed [15:0] lo_reg;
    logic signed [15:0] hi_reg;
    logic first_reg;
    logic signed [15:0] smp;
    logic signed [23:0] sum_next;
    logic signed [15:0] lo_next;
    logic signed [15:0] hi_next;

    assign smp = $signed(sample_in);
    assign sum_next = sum_reg + {{8{sample_in[15]}}, sample_in}; // RULE3
    assign lo_next = (first_reg || smp < lo_reg) ? smp : lo_reg; // RULE3
    assign hi_next = (first_reg || smp > hi_reg) ? smp : hi_reg; // RULE3

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sum_reg <= 24'sh000000;
            lo_reg <= 16'sh0000;
            hi_reg <= 16'sh0000;
            first_reg <= 1'b1;
            now_out <= `LTPM_WORD_RESET;
            avg_out <= `LTPM_WORD_RESET;
            min_out <= `LTPM_WORD_RESET;
            max_out <= `LTPM_WORD_RESET;
        end
        else if (sample_valid_in)
        begin
            now_out <= sample_in;
            if (interval_end_in)
            begin
                avg_out <= sum_next[23:`LTPM_PM_SHIFT];
                min_out <= lo_next;
                max_out <= hi_next;
                sum_reg <= 24'sh000000;
                first_reg <= 1'b1;
            end
            else
            begin
                sum_reg <= sum_next;
                lo_reg <= lo_next;
                hi_reg <= hi_next;
                first_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_min_below_max: assert property ( // RULE3
        sample_valid_in && interval_end_in |=> $signed(min_out) <= $signed(max_out))
        else $error("interval minimum above maximum");

    chk_now_follows: assert property ( // RULE4
        !rst_in && sample_valid_in |=> now_out == $past(sample_in))
        else $error("present value not the last sample");

endmodule : ltpm_pm_stats

`default_nettype wire

// >>> rtl/ltpm_regs.sv
`include "ltpm_defs.svh"
`default_nettype none

module ltpm_regs (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rd_data_out,
    input wire logic [255:0] freq_coarse_in,
    input wire logic [255:0] freq_fine_in,
    input wire logic [47:0] hires_freq_in,
    input wire logic [15:0] hires_en_in,
    input wire logic pm_sample_valid_in,
    input wire logic [255:0] tx_power_in,
    input wire logic [255:0] rx_power_in,
    output logic [47:0] hires_min_freq_out,
    output logic [15:0] use_hires_out,
    output logic [15:0] retune_out,
    output logic pm_interval_end_out
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic in_lane_block(input logic [15:0] addr, input logic [15:0] base);
        in_lane_block = (addr[15:4] == base[15:4]);
    endfunction : in_lane_block

    function automatic logic in_word_triple(input logic [15:0] addr, input logic [15:0] base);
        in_word_triple = (addr >= base) && (addr <= base + 16'h0002);
    endfunction : in_word_triple

    logic [3:0] lane;
    logic [1:0] word_idx_min;
    logic [1:0] word_idx_rd;
    logic hit_coarse;
    logic hit_fine;
    logic hit_min;
    logic hit_rd;
    logic hit_tx_now;
    logic hit_tx_avg;
    logic hit_tx_min;
    logic hit_tx_max;
    logic hit_rx_now;
    logic hit_rx_avg;
    ltpm_pkg::ltpm_src_t src;

    assign lane = addr_in[3:0]; // RULE8
    assign word_idx_min = 2'(addr_in - `LTPM_OFF_MIN_FREQ1);
    assign word_idx_rd = 2'(addr_in - `LTPM_OFF_FREQ_RD1);
    assign hit_coarse = in_lane_block(addr_in, `LTPM_OFF_FREQ_COARSE); // RULE8
    assign hit_fine = in_lane_block(addr_in, `LTPM_OFF_FREQ_FINE);
    assign hit_min = in_word_triple(addr_in, `LTPM_OFF_MIN_FREQ1); // RULE6
    assign hit_rd = in_word_triple(addr_in, `LTPM_OFF_FREQ_RD1); // RULE7
    assign hit_tx_now = in_lane_block(addr_in, `LTPM_OFF_TX_NOW);
    assign hit_tx_avg = in_lane_block(addr_in, `LTPM_OFF_TX_AVG);
    assign hit_tx_min = in_lane_block(addr_in, `LTPM_OFF_TX_MIN);
    assign hit_tx_max = in_lane_block(addr_in, `LTPM_OFF_TX_MAX);
    assign hit_rx_now = in_lane_block(addr_in, `LTPM_OFF_RX_NOW);
    assign hit_rx_avg = in_lane_block(addr_in, `LTPM_OFF_RX_AVG);

    // anything not named here, reserved blocks included, falls to none
    assign src = hit_coarse ? ltpm_pkg::LTPM_SRC_COARSE :
        hit_fine ? ltpm_pkg::LTPM_SRC_FINE :
        hit_min ? ltpm_pkg::LTPM_SRC_MIN_FREQ :
        hit_rd ? ltpm_pkg::LTPM_SRC_FREQ_RD :
        hit_tx_now ? ltpm_pkg::LTPM_SRC_TX_NOW :
        hit_tx_avg ? ltpm_pkg::LTPM_SRC_TX_AVG :
        hit_tx_min ? ltpm_pkg::LTPM_SRC_TX_MIN :
        hit_tx_max ? ltpm_pkg::LTPM_SRC_TX_MAX :
        hit_rx_now ? ltpm_pkg::LTPM_SRC_RX_NOW :
        hit_rx_avg ? ltpm_pkg::LTPM_SRC_RX_AVG :
        ltpm_pkg::LTPM_SRC_NONE; // RULE10

    // ----------------------------------------------------------------
    // writable minimum frequency words
    // ----------------------------------------------------------------
    ltpm_pkg::ltpm_word_t min_freq_reg [3];
    logic min_wr;

    assign min_wr = wr_in && hit_min; // RULE6

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            min_freq_reg[0] <= `LTPM_WORD_RESET;
            min_freq_reg[1] <= `LTPM_WORD_RESET;
            min_freq_reg[2] <= `LTPM_WORD_RESET;
        end
        else if (min_wr)
        begin
            min_freq_reg[word_idx_min] <= wr_data_in; // RULE6
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            hires_min_freq_out <= 48'h000000000000;
        else
            hires_min_freq_out <= {min_freq_reg[2], min_freq_reg[1], min_freq_reg[0]};
    end

    // ----------------------------------------------------------------
    // lane views of the live inputs
    // ----------------------------------------------------------------
    ltpm_pkg::ltpm_word_t coarse_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t fine_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t tx_now_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t tx_avg_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t tx_min_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t tx_max_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t rx_now_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t rx_avg_w [`LTPM_NUM_LANES];
    ltpm_pkg::ltpm_word_t freq_rd_w [3];
    logic [7:0] pm_cnt_reg;
    logic pm_end;

    // the interval closes on a fixed count of samples
    assign pm_end = pm_sample_valid_in && (pm_cnt_reg == `LTPM_PM_LAST);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            pm_cnt_reg <= 8'h00;
        else if (pm_sample_valid_in)
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            pm_interval_end_out <= 1'b0;
        else
            pm_interval_end_out <= pm_end;
    end

    genvar g;
    generate
        for (g = 0; g < `LTPM_NUM_LANES; g++)
        begin : gen_lane
            assign coarse_w[g] = freq_coarse_in[16*g +: 16]; // RULE1
            assign fine_w[g] = freq_fine_in[16*g +: 16]; // RULE2

            ltpm_pm_stats u_tx_stats (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .sample_valid_in(pm_sample_valid_in),
                .interval_end_in(pm_end),
                .sample_in(tx_power_in[16*g +: 16]),
                .now_out(tx_now_w[g]),
                .avg_out(tx_avg_w[g]),
                .min_out(tx_min_w[g]),
                .max_out(tx_max_w[g])
            ); // RULE4

            ltpm_pm_stats u_rx_stats (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .sample_valid_in(pm_sample_valid_in),
                .interval_end_in(pm_end),
                .sample_in(rx_power_in[16*g +: 16]),
                .now_out(rx_now_w[g]),
                .avg_out(rx_avg_w[g]),
                .min_out(),
                .max_out()
            ); // RULE5
        end
        for (g = 0; g < 3; g++)
        begin : gen_freq_rd
            assign freq_rd_w[g] = hires_freq_in[16*g +: 16]; // RULE7
        end
    endgenerate

    // ----------------------------------------------------------------
    // tuning source selection
    // ----------------------------------------------------------------
    ltpm_tune_sel u_tune_sel (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hires_en_in(hires_en_in),
        .words_written_in(min_wr),
        .use_hires_out(use_hires_out),
        .retune_out(retune_out)
    ); // RULE9

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    ltpm_pkg::ltpm_word_t rd_mux;

    assign rd_mux = (src == ltpm_pkg::LTPM_SRC_COARSE) ? coarse_w[lane] : // RULE1
        (src == ltpm_pkg::LTPM_SRC_FINE) ? fine_w[lane] : // RULE2
        (src == ltpm_pkg::LTPM_SRC_MIN_FREQ) ? min_freq_reg[word_idx_min] :
        (src == ltpm_pkg::LTPM_SRC_FREQ_RD) ? freq_rd_w[word_idx_rd] :
        (src == ltpm_pkg::LTPM_SRC_TX_NOW) ? tx_now_w[lane] :
        (src == ltpm_pkg::LTPM_SRC_TX_AVG) ? tx_avg_w[lane] :
        (src == ltpm_pkg::LTPM_SRC_TX_MIN) ? tx_min_w[lane] :
        (src == ltpm_pkg::LTPM_SRC_TX_MAX) ? tx_max_w[lane] :
        (src == ltpm_pkg::LTPM_SRC_RX_NOW) ? rx_now_w[lane] :
        (src == ltpm_pkg::LTPM_SRC_RX_AVG) ? rx_avg_w[lane] :
        `LTPM_WORD_RESET; // RULE10

    // data is held only for the cycle after the strobe; zero otherwise
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rd_data_out <= `LTPM_WORD_RESET;
        else if (rd_in)
            rd_data_out <= rd_mux;
        else
            rd_data_out <= `LTPM_WORD_RESET;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_min_write;
        wr_in && hit_min;
    endsequence

    sequence s_min_read_back;
        !wr_in && rd_in && addr_in == $past(addr_in);
    endsequence

    chk_coarse_readback: assert property ( // RULE1
        rd_in && hit_coarse |=> rd_data_out == $past(coarse_w[lane]))
        else $error("coarse frequency readback wrong");

    chk_fine_readback: assert property ( // RULE2
        rd_in && hit_fine |=> rd_data_out == $past(freq_fine_in[16*lane +: 16]))
        else $error("fine frequency readback wrong");

    chk_min_write_read: assert property ( // RULE6
        s_min_write ##1 s_min_read_back |=>
        rd_data_out == $past(wr_data_in, 2))
        else $error("minimum frequency word not stored");

    chk_freq_rd_ro: assert property ( // RULE7
        rd_in && hit_rd |=> rd_data_out == $past(hires_freq_in[16*word_idx_rd +: 16]))
        else $error("tuned frequency word readback wrong");

    chk_lane_select: assert property ( // RULE8
        rd_in && hit_tx_now |=> rd_data_out == $past(tx_now_w[addr_in[3:0]]))
        else $error("lane index not taken from low address bits");

    chk_tx_reset_zero: assert property ( // RULE4
        $fell(rst_in) |-> tx_now_w[0] == 16'h0000 && tx_max_w[0] == 16'h0000)
        else $error("transmit power not cleared at reset");

    chk_rx_reset_zero: assert property ( // RULE5
        $fell(rst_in) |-> rx_now_w[0] == 16'h0000 && rx_avg_w[0] == 16'h0000)
        else $error("receive power not cleared at reset");

    chk_rsvd_read_zero: assert property ( // RULE10
        rd_in && src == ltpm_pkg::LTPM_SRC_NONE |=> rd_data_out == 16'h0000)
        else $error("reserved location read non zero");

    chk_rsvd_write_ignored: assert property ( // RULE10
        wr_in && !hit_min |-> ##2 $stable(hires_min_freq_out))
        else $error("write outside writable words changed state");

    chk_interval_pulse: assert property ( // RULE4
        pm_sample_valid_in && pm_cnt_reg == 8'hff |=> pm_interval_end_out ##1 !pm_interval_end_out)
        else $error("interval end not a single pulse");

endmodule : ltpm_regs

`default_nettype wire

// >>> rtl/ltpm_tune_sel.sv
`include "ltpm_defs.svh"
`default_nettype none

module ltpm_tune_sel (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] hires_en_in,
    input wire logic words_written_in,
    output logic [15:0] use_hires_out,
    output logic [15:0] retune_out
);

    // ----------------------------------------------------------------
    // per lane choice of tuning source
    // ----------------------------------------------------------------
    // a lane is retuned when its mode flips, or when any of the shared words is written
    // while it is already in high resolution mode
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            use_hires_out <= 16'h0000;
            retune_out <= 16'h0000;
        end
        else
        begin
            use_hires_out <= hires_en_in; // RULE9
            retune_out <= (hires_en_in ^ use_hires_out) |
                (hires_en_in & {16{words_written_in}}); // RULE9
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_mode_follows_en: assert property ( // RULE9
        !rst_in |=> use_hires_out == $past(hires_en_in))
        else $error("tuning mode does not follow lane enable");

    chk_retune_on_flip: assert property ( // RULE9
        !rst_in && hires_en_in != use_hires_out |=> retune_out != 16'h0000)
        else $error("mode change without retune");

endmodule : ltpm_tune_sel

`default_nettype wire
